// *** rtl/nfc_buf_if.sv ***
// Interface carrying one byte stream with valid and ready.
`timescale 1ns/1ps
interface nfc_buf_if;
  logic       valid;
  logic       ready;
  logic [7:0] data;
  modport src (output valid, output data, input ready);
  modport dst (input valid, input data, output ready);
endinterface : nfc_buf_if

// *** rtl/nfc_host.sv ***
// Host controller that sequences commands to an asynchronous NAND flash.
`timescale 1ns/1ps
// Overview of operation
// - Only defined opcodes from the package are ever driven.
// - While busy, only status read or reset commands are issued.
// - After serial data input, only column change, confirm or reset.
// - Programs pages of a block in ascending order only until an erase or a request names another block.
// - Each page is programmed at most four times between erases or requests to another block.
// - Block is bad when its marker byte reads zero.
// - Erase requests to known bad blocks are refused.
// - Status is read after erase; failing blocks are retired.
// - On program failure the block is retired and failure reported.
// - Read data carries eight-bit per 512-byte ECC outside this block.
// - Corrected-error tracking and rewrite are left to software.
// - Unused page areas are filled with ones.
module nfc_host #(
  parameter int BLK_W   = 11,
  parameter int PAGE_W  = 6,
  parameter int NBLK    = 2048,
  parameter int NPAGE   = 64
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst_b,
  // User request
  input  wire logic              req_valid,
  input  wire logic [1:0]        req_kind,
  input  wire logic [BLK_W-1:0]  req_blk,
  input  wire logic [PAGE_W-1:0] req_page,
  input  wire logic [15:0]       req_col,
  input  wire logic [15:0]       req_len,
  output logic                   req_ready,
  // User write data
  input  wire logic              wr_valid,
  input  wire logic [7:0]        wr_data,
  output logic                   wr_ready,
  // User read data
  output logic                   rd_valid,
  output logic [7:0]             rd_data,
  input  wire logic              rd_ready,
  // Completion
  output logic                   done,
  output logic                   fail,
  output logic                   refused,
  // Flash pins
  output logic                   cle,
  output logic                   ale,
  output logic                   we_b,
  output logic                   re_b,
  output logic                   ce_b,
  output logic                   wp_b,
  output logic [7:0]             io_o,
  output logic                   io_oe,
  input  wire logic [7:0]        io_i,
  input  wire logic              ready_busy_line
);
  typedef enum logic [3:0] {
    S_INIT, S_IDLE, S_CMD, S_ADDR, S_WAIT, S_WDATA, S_RDATA,
    S_STAT, S_STATRD, S_DONE
  } nfc_state_t;
  typedef struct packed {
    nfc_state_t           st;
    logic [2:0]           ph;
    logic [7:0]           cmd;
    logic [2:0]           acnt;
    logic [15:0]          cnt;
    logic [1:0]           kind;
    logic [BLK_W-1:0]     blk;
    logic [PAGE_W-1:0]    page;
    logic [15:0]          col;
    logic                 second;
    logic [PAGE_W:0]      next_pg;
    logic [2:0]           npart;
    logic                 cle, ale, we_b, re_b, ce_b, wp_b, oe;
    logic [7:0]           io;
    logic                 rq_rdy, wr_rdy, done, fail, refused;
    logic                 rb1, rb2;
    logic [7:0]           in1, in2;
    logic                 pv;
    logic [7:0]           pd;
  } nfc_host_t;
  nfc_host_t s_q, s_d;
  logic [NBLK-1:0] bad_q, bad_d;
  nfc_buf_if rb_in ();
  nfc_buf_if rb_out ();
  // ---------------------------------------------------------------------
  // Read buffer
  // ---------------------------------------------------------------------
  nfc_skid #(.W(8)) u_skid (
    .clk   (clk),
    .rst_b (rst_b),
    .in_s  (rb_in.dst),
    .out_s (rb_out.src)
  );
  assign rb_in.valid  = s_q.pv;
  assign rb_in.data   = s_q.pd;
  assign rb_out.ready = rd_ready;
  function automatic logic [7:0] addr_byte(input logic [2:0] i,
      input logic [15:0] c, input logic [23:0] r);
    case (i)
      3'h0:    addr_byte = c[7:0];
      3'h1:    addr_byte = c[15:8];
      3'h2:    addr_byte = r[7:0];
      3'h3:    addr_byte = r[15:8];
      default: addr_byte = r[23:16];
    endcase
  endfunction : addr_byte
  // ---------------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------------
  logic [23:0] row;
  always_comb begin
    s_d = s_q;
    bad_d = bad_q;
    row = 24'(({s_q.blk, s_q.page}));
    s_d.rb1 = ready_busy_line;
    s_d.rb2 = s_q.rb1;
    s_d.in1 = io_i;
    s_d.in2 = s_q.in1;
    s_d.done = 1'b0;
    s_d.refused = 1'b0;
    s_d.rq_rdy = 1'b0;
    s_d.wr_rdy = 1'b0;
    if (rb_in.ready) begin
      s_d.pv = 1'b0;
    end
    case (s_q.st)
      S_INIT: begin
        s_d.cmd = nfc_pkg::OP_RESET;
        s_d.kind = nfc_pkg::REQ_RESET;
        if (s_q.rb2) begin
          s_d.st = S_CMD;
        end
      end
      S_IDLE: begin
        s_d.ce_b = 1'b1;
        s_d.rq_rdy = 1'b1;
        if (req_valid && s_q.rq_rdy) begin
          s_d.rq_rdy = 1'b0;
          s_d.kind = req_kind;
          s_d.blk = req_blk;
          s_d.page = req_page;
          s_d.col = req_col;
          s_d.cnt = req_len;
          s_d.second = 1'b0;
          s_d.fail = 1'b0;
          if (req_blk != s_q.blk) begin
            s_d.next_pg = '0;
            s_d.npart = '0;
          end
          case (req_kind)
            nfc_pkg::REQ_READ:  s_d.cmd = nfc_pkg::OP_READ1;
            nfc_pkg::REQ_PROG:  s_d.cmd = nfc_pkg::OP_SDIN;
            nfc_pkg::REQ_ERASE: s_d.cmd = nfc_pkg::OP_ERASE1;
            default:            s_d.cmd = nfc_pkg::OP_RESET;
          endcase
          if (req_kind != nfc_pkg::REQ_RESET && bad_q[req_blk]) begin
            s_d.refused = 1'b1;
          end else if (req_kind == nfc_pkg::REQ_PROG &&
              ((req_blk == s_q.blk && {1'b0, req_page} + 1'b1 ==
              s_q.next_pg && s_q.npart == 3'(nfc_pkg::MAX_PARTIAL)) ||
              ({1'b0, req_page} < (req_blk == s_q.blk ? s_q.next_pg :
              '0) - ((req_blk == s_q.blk && s_q.next_pg != '0) ?
              1'b1 : 1'b0)))) begin
            s_d.refused = 1'b1;
          end else if (s_q.rb2) begin
            s_d.st = S_CMD;
          end else begin
            s_d.refused = 1'b1;
          end
        end
      end
      S_CMD: begin
        s_d.ce_b = 1'b0;
        s_d.cle = 1'b1;
        s_d.oe = 1'b1;
        s_d.io = s_q.cmd;
        // The strobe rises one cycle before the latch enable drops.
        s_d.we_b = (s_q.ph != 3'h0);
        s_d.ph = s_q.ph + 3'h1;
        if (s_q.ph == 3'h2) begin
          s_d.ph = '0;
          s_d.cle = 1'b0;
          s_d.acnt = '0;
          case (s_q.cmd)
            nfc_pkg::OP_READ1, nfc_pkg::OP_SDIN: s_d.st = S_ADDR;
            nfc_pkg::OP_ERASE1: begin
              s_d.acnt = 3'h2;
              s_d.st = S_ADDR;
            end
            nfc_pkg::OP_STATUS: s_d.st = S_STATRD;
            default: s_d.st = S_WAIT;
          endcase
        end
      end
      S_ADDR: begin
        s_d.ale = 1'b1;
        s_d.oe = 1'b1;
        s_d.io = addr_byte(s_q.acnt, s_q.col, row);
        s_d.we_b = (s_q.ph != 3'h0);
        s_d.ph = s_q.ph + 3'h1;
        if (s_q.ph == 3'h2) begin
          s_d.ph = '0;
          s_d.acnt = s_q.acnt + 3'h1;
          if (s_q.acnt == 3'(nfc_pkg::ADDR_CYCLES - 1)) begin
            s_d.ale = 1'b0;
            if (s_q.cmd == nfc_pkg::OP_SDIN) begin
              s_d.st = S_WDATA;
            end else begin
              s_d.cmd = (s_q.cmd == nfc_pkg::OP_READ1) ?
                nfc_pkg::OP_READ2 : nfc_pkg::OP_ERASE2;
              s_d.st = S_CMD;
            end
          end
        end
      end
      S_WDATA: begin
        s_d.oe = 1'b1;
        s_d.we_b = (s_q.ph != 3'h0);
        s_d.ph = (s_q.ph == 3'h0) ? 3'h1 : 3'h0;
        if (s_q.ph == 3'h0) begin
          s_d.wr_rdy = 1'b1;
          // Missing user data is padded with ones, never zeros.
          s_d.io = wr_valid ? wr_data : nfc_pkg::FILL_ONES;
          s_d.cnt = s_q.cnt - 16'h1;
        end else if (s_q.cnt == 16'h0) begin
          // Confirm only once the last byte has seen its rising strobe.
          s_d.cmd = nfc_pkg::OP_PROG;
          s_d.st = S_CMD;
        end
      end
      S_WAIT: begin
        s_d.oe = 1'b0;
        s_d.ph = s_q.ph + 3'(s_q.ph != 3'h7);
        if (s_q.ph == 3'h7 && s_q.rb2) begin
          s_d.ph = '0;
          if (s_q.kind == nfc_pkg::REQ_READ) begin
            s_d.st = S_RDATA;
          end else if (s_q.kind == nfc_pkg::REQ_RESET) begin
            s_d.st = S_DONE;
          end else begin
            s_d.cmd = nfc_pkg::OP_STATUS;
            s_d.st = S_CMD;
          end
        end
      end
      S_RDATA: begin
        s_d.oe = 1'b0;
        // Only a new byte waits for room; a started one must finish.
        if (s_q.ph != 3'h0 || !s_q.pv || rb_in.ready) begin
          s_d.re_b = (s_q.ph >= 3'h2);
          s_d.ph = (s_q.ph == 3'h3) ? 3'h0 : s_q.ph + 3'h1;
          if (s_q.ph == 3'h3) begin
            s_d.pv = 1'b1;
            s_d.pd = s_q.in2;
            s_d.cnt = s_q.cnt - 16'h1;
            // A zero marker flags the block as bad.
            if (s_q.in2 == nfc_pkg::BAD_MARK && !s_q.second) begin
              s_d.fail = 1'b1;
              bad_d[s_q.blk] = 1'b1;
            end
            s_d.second = 1'b1;
            if (s_q.cnt == 16'h1) begin
              s_d.st = S_DONE;
            end
          end
        end
      end
      S_STATRD: begin
        s_d.oe = 1'b0;
        s_d.re_b = (s_q.ph >= 3'h2);
        s_d.ph = s_q.ph + 3'h1;
        if (s_q.ph == 3'h3) begin
          s_d.ph = '0;
          if (s_q.in2[nfc_pkg::ST_READY_BIT]) begin
            s_d.fail = s_q.in2[nfc_pkg::ST_FAIL_BIT];
            if (s_q.in2[nfc_pkg::ST_FAIL_BIT]) begin
              bad_d[s_q.blk] = 1'b1;
            end
            if (s_q.kind == nfc_pkg::REQ_PROG) begin
              s_d.npart = (s_q.next_pg == {1'b0, s_q.page} + 1'b1) ?
                s_q.npart + 3'h1 : 3'h1;
              s_d.next_pg = {1'b0, s_q.page} + 1'b1;
            end
            if (s_q.kind == nfc_pkg::REQ_ERASE) begin
              s_d.next_pg = '0;
              s_d.npart = '0;
            end
            s_d.st = S_DONE;
          end
        end
      end
      S_DONE: begin
        s_d.re_b = 1'b1;
        s_d.we_b = 1'b1;
        s_d.done = 1'b1;
        s_d.st = S_IDLE;
      end
      default: s_d.st = S_IDLE;
    endcase
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_q <= '{st: S_INIT, cmd: 8'h00, we_b: 1'b1, re_b: 1'b1,
               ce_b: 1'b1, wp_b: 1'b1, default: '0};
      bad_q <= '0;
    end else begin
      s_q <= s_d;
      bad_q <= bad_d;
    end
  end
  // ---------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------
  assign req_ready = s_q.rq_rdy;
  assign wr_ready  = s_q.wr_rdy;
  assign rd_valid  = rb_out.valid;
  assign rd_data   = rb_out.data;
  assign done      = s_q.done;
  assign fail      = s_q.fail;
  assign refused   = s_q.refused;
  assign cle       = s_q.cle;
  assign ale       = s_q.ale;
  assign we_b      = s_q.we_b;
  assign re_b      = s_q.re_b;
  assign ce_b      = s_q.ce_b;
  assign wp_b      = s_q.wp_b;
  assign io_o      = s_q.io;
  assign io_oe     = s_q.oe;
  // ---------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------
  busy_cmd_a: assert property (@(posedge clk) disable iff (!rst_b)
    s_q.st == S_IDLE && s_d.st == S_CMD |-> s_q.rb2)
    else $error("command started while busy");
  bad_erase_a: assert property (@(posedge clk) disable iff (!rst_b)
    s_q.st == S_IDLE && s_d.st == S_CMD && s_d.kind != nfc_pkg::REQ_RESET
    |-> !bad_q[s_d.blk]) else $error("access to bad block");
  cle_ale_a: assert property (@(posedge clk) disable iff (!rst_b)
    !(cle && ale)) else $error("cle and ale together");
  sdin_next_a: assert property (@(posedge clk) disable iff (!rst_b)
    s_q.st == S_WDATA && s_d.st == S_CMD |-> s_d.cmd == nfc_pkg::OP_PROG)
    else $error("bad opcode after data input");
  five_addr_a: assert property (@(posedge clk) disable iff (!rst_b)
    s_q.st == S_ADDR |-> s_q.acnt < 3'(nfc_pkg::ADDR_CYCLES))
    else $error("sixth address cycle");
  stat_fail_a: assert property (@(posedge clk) disable iff (!rst_b)
    s_q.st == S_STATRD && s_d.st == S_DONE && s_q.in2[0]
    |=> bad_q[s_q.blk] ##1 done) else $error("failed block not retired");
  cov_prog_c: cover property (@(posedge clk) disable iff (!rst_b)
    s_q.st == S_WDATA ##[1:200] done);
  cov_read_c: cover property (@(posedge clk) disable iff (!rst_b)
    s_q.st == S_RDATA ##[1:200] done);
  cov_ref_c: cover property (@(posedge clk) disable iff (!rst_b) refused);
endmodule : nfc_host

// *** rtl/nfc_pkg.sv ***
// Package with command codes, pin timing and limits of the flash controller.
package nfc_pkg;
  // ---------------------------------------------------------------------
  // Opcodes
  // ---------------------------------------------------------------------
  localparam logic [7:0] OP_READ1   = 8'h00;
  localparam logic [7:0] OP_READ2   = 8'h30;
  localparam logic [7:0] OP_SDIN    = 8'h80;
  localparam logic [7:0] OP_COLCHG  = 8'h85;
  localparam logic [7:0] OP_PROG    = 8'h10;
  localparam logic [7:0] OP_MPROG   = 8'h11;
  localparam logic [7:0] OP_CPROG   = 8'h15;
  localparam logic [7:0] OP_ERASE1  = 8'h60;
  localparam logic [7:0] OP_ERASE2  = 8'hD0;
  localparam logic [7:0] OP_STATUS  = 8'h70;
  localparam logic [7:0] OP_STATUS2 = 8'h71;
  localparam logic [7:0] OP_RESET   = 8'hFF;
  // ---------------------------------------------------------------------
  // Request kinds
  // ---------------------------------------------------------------------
  localparam logic [1:0] REQ_READ  = 2'h0;
  localparam logic [1:0] REQ_PROG  = 2'h1;
  localparam logic [1:0] REQ_ERASE = 2'h2;
  localparam logic [1:0] REQ_RESET = 2'h3;
  // ---------------------------------------------------------------------
  // Status, limits and timing
  // ---------------------------------------------------------------------
  localparam int         ST_FAIL_BIT   = 0;
  localparam int         ST_READY_BIT  = 6;
  localparam logic [7:0] BAD_MARK      = 8'h00;
  localparam logic [7:0] FILL_ONES     = 8'hFF;
  localparam int         MAX_PARTIAL   = 4;
  localparam int         ADDR_CYCLES   = 5;
  localparam int         CLK_MHZ       = 10;
  localparam int         PIN_HOLD_NS   = 100;
  localparam int         PIN_HOLD_CYC  =
    (PIN_HOLD_NS * CLK_MHZ + 999) / 1000 < 1 ? 1 :
    (PIN_HOLD_NS * CLK_MHZ + 999) / 1000;
endpackage : nfc_pkg

// *** rtl/nfc_skid.sv ***
// Two-entry buffer between the flash read path and the user.
`timescale 1ns/1ps
module nfc_skid #(
  parameter int W = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Streams
  nfc_buf_if.dst   in_s,
  nfc_buf_if.src   out_s
);
  typedef struct packed {
    logic [1:0]   cnt;
    logic         vld;
    logic [W-1:0] e0;
    logic [W-1:0] e1;
  } nfc_skid_t;
  nfc_skid_t s_q, s_d;
  logic push, pop;
  assign in_s.ready  = (s_q.cnt != 2'h2);
  assign out_s.valid = s_q.vld;
  assign out_s.data  = s_q.e0;
  always_comb begin
    s_d  = s_q;
    push = in_s.valid && in_s.ready;
    pop  = out_s.valid && out_s.ready;
    if (pop) begin
      s_d.e0 = s_q.e1;
    end
    if (push) begin
      if (s_q.cnt == 2'h0 || (s_q.cnt == 2'h1 && pop)) begin
        s_d.e0 = in_s.data;
      end else begin
        s_d.e1 = in_s.data;
      end
    end
    s_d.cnt = s_q.cnt + {1'b0, push} - {1'b0, pop};
    s_d.vld = (s_d.cnt != 2'h0);
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
  never_over_a: assert property (@(posedge clk) disable iff (!rst_b)
    s_q.cnt <= 2'h2) else $error("buffer count overflow");
  keep_word_a: assert property (@(posedge clk) disable iff (!rst_b)
    out_s.valid && !out_s.ready |=> out_s.valid && $stable(out_s.data))
    else $error("stalled word changed");
  cover_full_c: cover property (@(posedge clk) disable iff (!rst_b)
    s_q.cnt == 2'h2);
endmodule : nfc_skid

// *** sim/nfc_nand_model.sv ***
// Behavioural flash device seen by the controller through its pins.
`timescale 1ns/1ps
module nfc_nand_model #(
  parameter int BUSY_NS = 2000,
  parameter int BAD_BLK = 5
) (
  // Flash pins
  input  wire logic       cle,
  input  wire logic       ale,
  input  wire logic       we_b,
  input  wire logic       re_b,
  input  wire logic       ce_b,
  input  wire logic       wp_b,
  input  wire logic [7:0] io_o,
  input  wire logic       io_oe,
  output logic [7:0]      io_i,
  output logic            ready_busy_line,
  // Test controls
  input  wire logic       inject_fail,
  output int              viol
);
  logic [7:0]  mem [longint];
  logic [7:0]  pbuf [longint];
  logic [7:0]  a [5];
  logic [7:0]  q;
  logic [23:0] row;
  logic [15:0] col;
  longint      ks [$];
  int          n;
  logic        busy, sdin, stat, st_fail;

  task automatic go_busy(int t);
    busy = 1'b1;
    fork #(t) busy = 1'b0; join_none
  endtask : go_busy

  // Open drain with pull-up: released means high.
  assign ready_busy_line = busy ? 1'b0 : 1'b1;

  initial begin
    viol = 0; n = 0; sdin = 0; stat = 0; st_fail = 0;
    row = 24'h0; col = 16'h0; q = 8'h5A; io_i = 8'hA5;
    foreach (a[i]) a[i] = 8'h00;
    mem[longint'(BAD_BLK) << 22] = 8'h00;
    go_busy(BUSY_NS);
  end

  always @(posedge we_b) if (!ce_b) begin
    if (!io_oe) viol++;
    if (cle) begin
      if (!(io_o inside {8'h00, 8'h30, 8'h80, 8'h85, 8'h10, 8'h11,
          8'h15, 8'h60, 8'hD0, 8'h70, 8'h71, 8'hFF})) viol++;
      if (busy && !(io_o inside {8'h70, 8'h71, 8'hFF}))
        viol++;
      if (sdin && !(io_o inside {8'h85, 8'h10, 8'h11, 8'h15, 8'hFF})) begin
        viol++;
        sdin = 1'b0;
      end
      if (io_o != 8'h70 && io_o != 8'h71) stat = 1'b0;
      case (io_o)
        8'h00, 8'h85: n = 0;
        8'h30: begin
          if (n != 5) viol++;
          go_busy(BUSY_NS);
        end
        8'h80: begin
          sdin = 1'b1;
          pbuf.delete();
          n = 0;
        end
        8'h10, 8'h11, 8'h15: begin
          if (n != 5) viol++;
          sdin = 1'b0;
          st_fail = inject_fail || !wp_b;
          if (!st_fail) foreach (pbuf[k])
            mem[k] = (mem.exists(k) ? mem[k] : 8'hFF) & pbuf[k];
          go_busy(BUSY_NS);
        end
        8'h60: n = 2;
        8'hD0: begin
          if (n != 5) viol++;
          st_fail = inject_fail || !wp_b;
          ks.delete();
          if (!st_fail) foreach (mem[k]) if ((k >> 22) == (row >> 6))
            ks.push_back(k);
          foreach (ks[i]) mem.delete(ks[i]);
          go_busy(BUSY_NS);
        end
        8'h70, 8'h71: stat = 1'b1;
        default: begin
          sdin = 1'b0;
          go_busy(200);
        end
      endcase
    end else if (ale) begin
      if (n < 5) a[n] = io_o;
      n++;
      row = {a[4], a[3], a[2]};
      col = {a[1], a[0]};
    end else if (sdin) begin
      pbuf[longint'({row, col})] = io_o;
      col++;
    end
  end

  // Write protect low cuts a running program or erase short.
  always @(negedge wp_b) if (busy) begin
    busy = 1'b0;
    st_fail = 1'b1;
  end

  always @(negedge re_b) if (!ce_b) begin
    if (stat) q = {wp_b, ~busy, ~busy, 4'h0, st_fail & ~busy};
    else begin
      q = mem.exists(longint'({row, col})) ? mem[longint'({row, col})]
                                            : 8'hFF;
      col++;
    end
    io_i = q;
  end

  // A released bus shows the inverse of the last byte.
  always @(posedge re_b) io_i = ~q;
endmodule : nfc_nand_model

// *** sim/testbench.sv ***
// Self-checking bench of the flash controller against the device model.
`timescale 1ns/1ps
module testbench;
  logic        clk, rst_b, req_valid, wr_valid, rd_ready, inject_fail;
  logic [1:0]  req_kind;
  logic [10:0] req_blk;
  logic [5:0]  req_page;
  logic [15:0] req_col, req_len;
  logic [7:0]  wr_data, rd_data, io_o, io_i;
  logic        req_ready, wr_ready, rd_valid, done, fail, refused;
  logic        cle, ale, we_b, re_b, ce_b, wp_b, io_oe, ready_busy_line;
  logic [31:0] seed;
  logic [7:0]  wbuf [$];
  logic [7:0]  rd_q [$];
  logic [1:0]  note_q [$];
  logic [1:0]  nt;
  int          fail_count, checks, wr_idx, skip, stall, cyc, viol, i;
  logic        pend;

  nfc_host i_nfc_host (
    .clk(clk), .rst_b(rst_b), .req_valid(req_valid), .req_kind(req_kind),
    .req_blk(req_blk), .req_page(req_page), .req_col(req_col),
    .req_len(req_len), .req_ready(req_ready), .wr_valid(wr_valid),
    .wr_data(wr_data), .wr_ready(wr_ready), .rd_valid(rd_valid),
    .rd_data(rd_data), .rd_ready(rd_ready), .done(done), .fail(fail),
    .refused(refused), .cle(cle), .ale(ale), .we_b(we_b), .re_b(re_b),
    .ce_b(ce_b), .wp_b(wp_b), .io_o(io_o), .io_oe(io_oe), .io_i(io_i),
    .ready_busy_line(ready_busy_line));

  nfc_nand_model i_nfc_nand_model (
    .cle(cle), .ale(ale), .we_b(we_b), .re_b(re_b), .ce_b(ce_b),
    .wp_b(wp_b), .io_o(io_o), .io_oe(io_oe), .io_i(io_i),
    .ready_busy_line(ready_busy_line), .inject_fail(inject_fail),
    .viol(viol));

  function automatic logic [31:0] lfsr(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  task automatic check(logic [31:0] got, logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t got %0h expected %0h", $time, got, exp);
    end
  endtask : check

  task automatic stop_test();
    if (fail_count == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : stop_test

  // One request; rf and fl note the expected refusal and fail level.
  task automatic op(logic [1:0] k, int b, int p, int c, int len,
                    logic rf, logic fl);
    int j;
    wr_idx = 0;
    note_q.push_back({rf, fl});
    @(negedge clk);
    req_valid = 1'b1; req_kind = k; req_blk = 11'(b); req_page = 6'(p);
    req_col = 16'(c); req_len = 16'(len);
    for (j = 0; j < 100 && req_ready !== 1'b1; j++) @(negedge clk);
    @(negedge clk);
    req_valid = 1'b0;
    for (j = 0; j < 5000 && !(done === 1'b1 || refused === 1'b1); j++)
      @(negedge clk);
    repeat (2) @(negedge clk);
  endtask : op

  task automatic fill(int len);
    wbuf.delete();
    repeat (len) begin
      seed = lfsr(seed);
      // A zero byte would read back as a bad-block marker.
      wbuf.push_back(seed[7:0] == nfc_pkg::BAD_MARK ? 8'h01 : seed[7:0]);
    end
  endtask : fill

  always #50 clk = ~clk;

  always @(posedge clk) begin
    if (wr_ready === 1'b1) wr_idx <= wr_idx + 1;
    if (rd_valid === 1'b1 && rd_ready === 1'b1) begin
      if (rd_q.size() == 0) check(1, 0);
      else check(rd_data, rd_q.pop_front());
    end
    cyc++;
    if (cyc == 40000) begin
      fail_count++;
      stop_test();
    end
  end

  always @(negedge clk) begin
    seed = lfsr(seed);
    rd_ready <= stall > 0 ? 1'b0 : seed[0] | seed[1];
    if (stall > 0) stall--;
    wr_valid <= wr_idx < wbuf.size() && wr_idx != skip;
    wr_data <= wr_idx < wbuf.size() ? wbuf[wr_idx] : 8'h00;
    if (pend) check(fail, nt[0]);
    pend = 1'b0;
    if (done === 1'b1 || refused === 1'b1) begin
      if (note_q.size() == 0) check(1, 0);
      else begin
        nt = note_q.pop_front();
        check(refused, nt[1]);
        pend = !nt[1];
      end
    end
  end

  initial begin
    clk = 1'b0; rst_b = 1'b0; req_valid = 1'b0; req_kind = 2'h0;
    req_blk = 11'h0; req_page = 6'h0; req_col = 16'h0; req_len = 16'h1;
    wr_valid = 1'b0; wr_data = 8'h00; rd_ready = 1'b0; inject_fail = 1'b0;
    seed = 32'hc8c2; fail_count = 0; checks = 0; wr_idx = 0; skip = -1;
    stall = 0; cyc = 0; pend = 1'b0; nt = 2'h0;
    note_q.push_back(2'h0);
    repeat (5) @(posedge clk);
    @(negedge clk) rst_b = 1'b1;
    for (i = 0; i < 3000 && done !== 1'b1; i++) @(negedge clk);
    repeat (2) @(negedge clk);
    // Program with one empty slot, then read back through a stall.
    fill(6);
    skip = 3;
    op(nfc_pkg::REQ_PROG, 1, 2, 0, 6, 1'b0, 1'b0);
    foreach (wbuf[j]) rd_q.push_back(j == 3 ? nfc_pkg::FILL_ONES : wbuf[j]);
    skip = -1;
    stall = 60;
    op(nfc_pkg::REQ_READ, 1, 2, 0, 6, 1'b0, 1'b0);
    op(nfc_pkg::REQ_PROG, 1, 1, 0, 2, 1'b1, 1'b0);
    // Three more partial programs on the page, the next is refused.
    for (i = 0; i < 4; i++) begin
      fill(2);
      if (i < 3) foreach (wbuf[j]) rd_q.push_back(wbuf[j]);
      op(nfc_pkg::REQ_PROG, 1, 2, 8 + 2 * i, 2, i == 3, 1'b0);
    end
    op(nfc_pkg::REQ_READ, 1, 2, 8, 6, 1'b0, 1'b0);
    inject_fail = 1'b1;
    op(nfc_pkg::REQ_ERASE, 3, 0, 0, 1, 1'b0, 1'b1);
    op(nfc_pkg::REQ_PROG, 7, 0, 0, 2, 1'b0, 1'b1);
    inject_fail = 1'b0;
    op(nfc_pkg::REQ_ERASE, 3, 0, 0, 1, 1'b1, 1'b0);
    op(nfc_pkg::REQ_PROG, 7, 1, 0, 2, 1'b1, 1'b0);
    rd_q.push_back(nfc_pkg::BAD_MARK);
    op(nfc_pkg::REQ_READ, 5, 0, 0, 1, 1'b0, 1'b1);
    op(nfc_pkg::REQ_ERASE, 5, 0, 0, 1, 1'b1, 1'b0);
    // A good erase leaves the page reading all ones.
    op(nfc_pkg::REQ_ERASE, 1, 0, 0, 1, 1'b0, 1'b0);
    rd_q.push_back(8'hFF);
    rd_q.push_back(8'hFF);
    op(nfc_pkg::REQ_READ, 1, 2, 0, 2, 1'b0, 1'b0);
    op(nfc_pkg::REQ_RESET, 0, 0, 0, 1, 1'b0, 1'b0);
    check(viol, 0);
    check(rd_q.size() + note_q.size(), 0);
    check(wp_b, 1'b1);
    stop_test();
  end
endmodule : testbench
